// File: verilog/secl_pkg.sv
// Shared constants, codes and state types of the serial EEPROM command logic
package secl_pkg;

  // Array geometry: rows of one full word, split into two bytes in byte mode
  localparam int SECL_ROWS = 256;
  localparam int SECL_ROW_AW = 8;
  localparam int SECL_WORD_W = 16;
  localparam int SECL_PTR_W = 9;
  localparam int SECL_CNT_W = 5;

  // Last header bit index after the start bit (opcode plus address), per organisation
  localparam logic [4:0] SECL_HDR_LAST_WORD = 5'h09;
  localparam logic [4:0] SECL_HDR_LAST_BYTE = 5'h0A;
  // Last data bit index, per organisation
  localparam logic [4:0] SECL_DAT_LAST_WORD = 5'h0F;
  localparam logic [4:0] SECL_DAT_LAST_BYTE = 5'h07;

  // Two-bit opcodes
  localparam logic [1:0] SECL_OP_EXT = 2'h0;
  localparam logic [1:0] SECL_OP_WRITE = 2'h1;
  localparam logic [1:0] SECL_OP_READ = 2'h2;
  localparam logic [1:0] SECL_OP_ERASE = 2'h3;

  // Extension codes carried in the two top address bits of opcode 00
  localparam logic [1:0] SECL_EXT_DISABLE = 2'h0;
  localparam logic [1:0] SECL_EXT_STORE_ALL = 2'h1;
  localparam logic [1:0] SECL_EXT_CLEAR_ALL = 2'h2;
  localparam logic [1:0] SECL_EXT_ENABLE = 2'h3;

  // Programming jobs handed from the serial side to the cycle timer
  localparam logic [1:0] SECL_JOB_WRITE = 2'h0;
  localparam logic [1:0] SECL_JOB_ERASE = 2'h1;
  localparam logic [1:0] SECL_JOB_CLEAR_ALL = 2'h2;
  localparam logic [1:0] SECL_JOB_STORE_ALL = 2'h3;

  // Byte lane enables, even byte address sits in the upper half
  localparam logic [1:0] SECL_BE_BOTH = 2'h3;
  localparam logic [1:0] SECL_BE_HIGH = 2'h2;
  localparam logic [1:0] SECL_BE_LOW = 2'h1;

  // Self-timed cycle length: longest allowed time, rounded down
  localparam int SECL_SYS_CLK_KHZ = 40000;
  localparam int SECL_T_EW_MS = 5;
  localparam int SECL_EW_CYCLES = SECL_T_EW_MS * SECL_SYS_CLK_KHZ;

  // Synchroniser bit positions in the system domain
  localparam int SECL_SY_CS = 0;
  localparam int SECL_SY_REQ = 1;
  localparam int SECL_SY_WEN = 2;
  localparam int SECL_SY_FRAME = 3;
  localparam int SECL_SY_RDOE = 4;
  localparam int SECL_SY_RDBIT = 5;
  localparam int SECL_SY_ORG = 6;
  localparam int SECL_SY_N = 7;

  typedef enum logic [4:0] {
    SECL_L_IDLE = 5'h01,
    SECL_L_HDR = 5'h02,
    SECL_L_DATA = 5'h04,
    SECL_L_READ = 5'h08,
    SECL_L_DONE = 5'h10
  } secl_link_st_t;

  typedef enum logic [1:0] {
    SECL_S_IDLE = 2'h1,
    SECL_S_BUSY = 2'h2
  } secl_sys_st_t;

endpackage

// File: verilog/secl_mem.sv
// Array storage: byte-laned write port and registered read port on separate clocks
`timescale 1ns/1ps
`default_nettype none
module secl_mem #(
  parameter int ROWS = 256,
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic wr_clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [1:0] wr_be_in,
  input wire logic rd_clk_in,
  input wire logic rd_en_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);
  localparam int HW = DW / 2;

  logic [DW-1:0] cells [ROWS];

  // Each byte lane is written only when its enable is set
  always_ff @(posedge wr_clk_in) begin
    if (wr_en_in && wr_be_in[1]) begin
      cells[wr_addr_in][DW-1:HW] <= wr_data_in[DW-1:HW];
    end
    if (wr_en_in && wr_be_in[0]) begin
      cells[wr_addr_in][HW-1:0] <= wr_data_in[HW-1:0];
    end
  end

  // Read data is held in a register until the next read strobe
  always_ff @(posedge rd_clk_in) begin
    if (rd_en_in) begin
      rd_data_out <= cells[rd_addr_in];
    end
  end
endmodule
`default_nettype wire

// File: verilog/secl_top.sv
// Serial EEPROM command decoder, sequential read and self-timed program control
`timescale 1ns/1ps
`default_nettype none
module secl_top import secl_pkg::*; #(
  parameter int EW_CYCLES = SECL_EW_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic serial_clk_in,
  input wire logic chip_sel_in,
  input wire logic serial_in,
  input wire logic word_size_sel_in,
  output logic serial_out,
  output logic serial_oe_out,
  output logic busy_out
);
  localparam int CW = $clog2(EW_CYCLES + 1);
  localparam logic [CW-1:0] EW_LAST = CW'(EW_CYCLES - 1);
  localparam logic [CW-1:0] ROWS_C = CW'(SECL_ROWS);

  // ---------------- Link domain (serial clock) ----------------
  secl_link_st_t lstate_ff;
  secl_link_st_t nxt_lstate;
  logic link_clr;
  logic [SECL_CNT_W-1:0] bit_cnt_ff;
  logic [10:0] hdr_ff;
  logic [15:0] dsh_ff;
  logic frame_ff;
  logic rd_oe_ff;
  logic rd_bit_ff;
  logic [15:0] rd_sh_ff;
  logic [SECL_CNT_W-1:0] rd_left_ff;
  logic [SECL_PTR_W-1:0] rd_ptr_ff;
  logic rd_half_ff;
  logic [1:0] pend_job_ff;
  logic [SECL_PTR_W-1:0] pend_addr_ff;
  logic [1:0] cap_job_ff;
  logic [SECL_PTR_W-1:0] cap_addr_ff;
  logic [15:0] cap_data_ff;
  logic req_ff;
  logic wen_ff;
  logic org1_ff;
  logic org2_ff;

  logic byte_l;
  logic [10:0] hdr_full;
  logic [15:0] dat_full;
  logic [1:0] op;
  logic [1:0] ext;
  logic [SECL_PTR_W-1:0] hdr_addr;
  logic hdr_done;
  logic dat_done;
  logic start_bit;
  logic rd_entry;
  logic rd_load;
  logic [SECL_PTR_W-1:0] ptr_nxt;
  logic [15:0] mem_rdata;
  logic [15:0] word_sel;
  logic mem_rd_en;
  logic [SECL_ROW_AW-1:0] mem_rd_row;

  // Shifter state is dropped whenever the device is deselected
  assign link_clr = reset_in | ~chip_sel_in;

  // Instruction decode on the bit being sampled at this edge
  always_comb begin
    byte_l = ~org2_ff;
    hdr_full = {hdr_ff[9:0], serial_in};
    dat_full = {dsh_ff[14:0], serial_in};
    if (byte_l) begin
      op = hdr_full[10:9];
      ext = hdr_full[8:7];
      hdr_addr = hdr_full[8:0];
      hdr_done = (lstate_ff == SECL_L_HDR) && (bit_cnt_ff == SECL_HDR_LAST_BYTE);
      dat_done = (lstate_ff == SECL_L_DATA) && (bit_cnt_ff == SECL_DAT_LAST_BYTE);
      ptr_nxt = rd_ptr_ff + 9'h001;
    end else begin
      op = hdr_full[9:8];
      ext = hdr_full[7:6];
      hdr_addr = {1'b0, hdr_full[7:0]};
      hdr_done = (lstate_ff == SECL_L_HDR) && (bit_cnt_ff == SECL_HDR_LAST_WORD);
      dat_done = (lstate_ff == SECL_L_DATA) && (bit_cnt_ff == SECL_DAT_LAST_WORD);
      ptr_nxt = {1'b0, rd_ptr_ff[7:0] + 8'h01};
    end
    start_bit = (lstate_ff == SECL_L_IDLE) && serial_in;
    rd_entry = hdr_done && (op == SECL_OP_READ);
    rd_load = (lstate_ff == SECL_L_READ) && (rd_left_ff == 5'h00);
  end

  // Read address: the new instruction address, or the next one while streaming
  always_comb begin
    mem_rd_en = rd_entry | rd_load;
    if (rd_entry) begin
      mem_rd_row = byte_l ? hdr_addr[8:1] : hdr_addr[7:0];
    end else begin
      mem_rd_row = byte_l ? ptr_nxt[8:1] : ptr_nxt[7:0];
    end
    // Byte words are left-aligned so the shifter always starts at bit 15
    if (!byte_l) begin
      word_sel = mem_rdata;
    end else if (rd_half_ff) begin
      word_sel = {mem_rdata[7:0], 8'h00};
    end else begin
      word_sel = {mem_rdata[15:8], 8'h00};
    end
  end

  // Next link state
  always_comb begin
    nxt_lstate = lstate_ff;
    case (lstate_ff)
      SECL_L_IDLE: begin
        if (start_bit) begin
          nxt_lstate = SECL_L_HDR;
        end
      end
      SECL_L_HDR: begin
        if (hdr_done) begin
          if (op == SECL_OP_READ) begin
            nxt_lstate = SECL_L_READ;
          end else if ((op == SECL_OP_WRITE) ||
                       ((op == SECL_OP_EXT) && (ext == SECL_EXT_STORE_ALL))) begin
            nxt_lstate = SECL_L_DATA;
          end else begin
            nxt_lstate = SECL_L_DONE;
          end
        end
      end
      SECL_L_DATA: begin
        if (dat_done) begin
          nxt_lstate = SECL_L_DONE;
        end
      end
      SECL_L_READ: nxt_lstate = SECL_L_READ;
      SECL_L_DONE: nxt_lstate = SECL_L_DONE;
      default: nxt_lstate = SECL_L_IDLE;
    endcase
  end

  // Link state, bit counter and input shifters, sampled on rising serial clock
  always_ff @(posedge serial_clk_in or posedge link_clr) begin
    if (link_clr) begin
      lstate_ff <= SECL_L_IDLE;
      bit_cnt_ff <= 5'h00;
      hdr_ff <= 11'h000;
      dsh_ff <= 16'h0000;
      frame_ff <= 1'b0;
    end else begin
      lstate_ff <= nxt_lstate;
      hdr_ff <= hdr_full;
      dsh_ff <= dat_full;
      if (start_bit) begin
        frame_ff <= 1'b1;
      end
      if (start_bit || hdr_done) begin
        bit_cnt_ff <= 5'h00;
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
    end
  end

  // Pending write-type job while its data field is still arriving
  always_ff @(posedge serial_clk_in or posedge link_clr) begin
    if (link_clr) begin
      pend_job_ff <= SECL_JOB_WRITE;
      pend_addr_ff <= 9'h000;
    end else if (hdr_done) begin
      pend_job_ff <= (op == SECL_OP_WRITE) ? SECL_JOB_WRITE : SECL_JOB_STORE_ALL;
      pend_addr_ff <= hdr_addr;
    end
  end

  // Read streamer: leading zero, then words MSB first with auto increment
  always_ff @(posedge serial_clk_in or posedge link_clr) begin
    if (link_clr) begin
      rd_oe_ff <= 1'b0;
      rd_bit_ff <= 1'b0;
      rd_sh_ff <= 16'h0000;
      rd_left_ff <= 5'h00;
      rd_ptr_ff <= 9'h000;
      rd_half_ff <= 1'b0;
    end else if (rd_entry) begin
      rd_oe_ff <= 1'b1;
      rd_bit_ff <= 1'b0;
      rd_left_ff <= 5'h00;
      rd_ptr_ff <= hdr_addr;
      rd_half_ff <= hdr_addr[0];
    end else if (rd_load) begin
      rd_bit_ff <= word_sel[15];
      rd_sh_ff <= {word_sel[14:0], 1'b0};
      rd_left_ff <= byte_l ? SECL_DAT_LAST_BYTE : SECL_DAT_LAST_WORD;
      rd_ptr_ff <= ptr_nxt;
      rd_half_ff <= ptr_nxt[0];
    end else if (lstate_ff == SECL_L_READ) begin
      rd_bit_ff <= rd_sh_ff[15];
      rd_sh_ff <= {rd_sh_ff[14:0], 1'b0};
      rd_left_ff <= rd_left_ff - 5'h01;
    end
  end

  // Completed instructions survive deselect so the cycle timer can pick them up
  always_ff @(posedge serial_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cap_job_ff <= SECL_JOB_WRITE;
      cap_addr_ff <= 9'h000;
      cap_data_ff <= 16'h0000;
      req_ff <= 1'b0;
    end else if (chip_sel_in) begin
      if (start_bit) begin
        req_ff <= 1'b0;
      end else if (hdr_done && (op == SECL_OP_ERASE)) begin
        cap_job_ff <= SECL_JOB_ERASE;
        cap_addr_ff <= hdr_addr;
        req_ff <= 1'b1;
      end else if (hdr_done && (op == SECL_OP_EXT) && (ext == SECL_EXT_CLEAR_ALL)) begin
        cap_job_ff <= SECL_JOB_CLEAR_ALL;
        req_ff <= 1'b1;
      end else if (dat_done) begin
        cap_job_ff <= pend_job_ff;
        cap_addr_ff <= pend_addr_ff;
        cap_data_ff <= byte_l ? {8'h00, dat_full[7:0]} : dat_full;
        req_ff <= 1'b1;
      end
    end
  end

  // Program enable latch, cleared only by reset or the disable instruction
  always_ff @(posedge serial_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wen_ff <= 1'b0;
    end else if (chip_sel_in && hdr_done && (op == SECL_OP_EXT)) begin
      if (ext == SECL_EXT_ENABLE) begin
        wen_ff <= 1'b1;
      end else if (ext == SECL_EXT_DISABLE) begin
        wen_ff <= 1'b0;
      end
    end
  end

  // Size select is a pin: two flops before the decoder uses it
  always_ff @(posedge serial_clk_in or posedge reset_in) begin
    if (reset_in) begin
      org1_ff <= 1'b1;
      org2_ff <= 1'b1;
    end else begin
      org1_ff <= word_size_sel_in;
      org2_ff <= org1_ff;
    end
  end

  // ---------------- System domain ----------------
  secl_sys_st_t sstate_ff;
  logic [SECL_SY_N-1:0] sync1_ff;
  logic [SECL_SY_N-1:0] sync2_ff;
  logic [SECL_SY_N-1:0] sync_in;
  logic cs_prev_ff;
  logic consumed_ff;
  logic stat_en_ff;
  logic [CW-1:0] ew_cnt_ff;
  logic [1:0] job_ff;
  logic [SECL_PTR_W-1:0] job_addr_ff;
  logic [15:0] job_data_ff;
  logic job_byte_ff;
  logic cs_fall;
  logic start_job;
  logic bulk;
  logic wr_en;
  logic [SECL_ROW_AW-1:0] wr_row;
  logic [15:0] wr_data;
  logic [1:0] wr_be;
  logic nxt_serial_out;
  logic nxt_serial_oe;

  assign sync_in = {word_size_sel_in, rd_bit_ff, rd_oe_ff, frame_ff, wen_ff, req_ff, chip_sel_in};

  // Two-flop synchronisers for the control levels crossing into this domain; the job fields are taken without them
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
    end else begin
      sync1_ff <= sync_in;
      sync2_ff <= sync1_ff;
    end
  end

  // A job starts at most once per completed instruction, on the deselect edge, only when enabled and idle
  always_comb begin
    cs_fall = cs_prev_ff & ~sync2_ff[SECL_SY_CS];
    start_job = cs_fall && sync2_ff[SECL_SY_REQ] && !consumed_ff &&
                sync2_ff[SECL_SY_WEN] && (sstate_ff == SECL_S_IDLE);
  end

  // Consumed marks the instruction as used, whether or not it was allowed
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cs_prev_ff <= 1'b0;
      consumed_ff <= 1'b0;
    end else begin
      cs_prev_ff <= sync2_ff[SECL_SY_CS];
      if (cs_fall && sync2_ff[SECL_SY_REQ]) begin
        consumed_ff <= 1'b1;
      end else if (!sync2_ff[SECL_SY_REQ]) begin
        consumed_ff <= 1'b0;
      end
    end
  end

  // Job fields are stable while deselected, so they are taken as words here
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      job_ff <= SECL_JOB_WRITE;
      job_addr_ff <= 9'h000;
      job_data_ff <= 16'h0000;
      job_byte_ff <= 1'b0;
    end else if (start_job) begin
      job_ff <= cap_job_ff;
      job_addr_ff <= cap_addr_ff;
      job_data_ff <= cap_data_ff;
      job_byte_ff <= ~sync2_ff[SECL_SY_ORG];
    end
  end

  // Self-timed cycle: fixed length, ready as soon as the count expires
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sstate_ff <= SECL_S_IDLE;
      ew_cnt_ff <= '0;
    end else begin
      case (sstate_ff)
        SECL_S_IDLE: begin
          ew_cnt_ff <= '0;
          if (start_job) begin
            sstate_ff <= SECL_S_BUSY;
          end
        end
        SECL_S_BUSY: begin
          if (ew_cnt_ff == EW_LAST) begin
            sstate_ff <= SECL_S_IDLE;
          end else begin
            ew_cnt_ff <= ew_cnt_ff + CW'(1);
          end
        end
        default: sstate_ff <= SECL_S_IDLE;
      endcase
    end
  end

  // Array writes: one row for location jobs, every row for bulk jobs
  always_comb begin
    bulk = (job_ff == SECL_JOB_CLEAR_ALL) || (job_ff == SECL_JOB_STORE_ALL);
    if (bulk) begin
      wr_en = (sstate_ff == SECL_S_BUSY) && (ew_cnt_ff < ROWS_C);
      wr_row = ew_cnt_ff[SECL_ROW_AW-1:0];
      wr_be = SECL_BE_BOTH;
    end else begin
      wr_en = (sstate_ff == SECL_S_BUSY) && (ew_cnt_ff == '0);
      wr_row = job_byte_ff ? job_addr_ff[8:1] : job_addr_ff[7:0];
      if (!job_byte_ff) begin
        wr_be = SECL_BE_BOTH;
      end else begin
        wr_be = job_addr_ff[0] ? SECL_BE_LOW : SECL_BE_HIGH;
      end
    end
    // Erase writes ones; a write overwrites its enabled byte lanes (one byte in byte mode), clearing old bits
    if ((job_ff == SECL_JOB_ERASE) || (job_ff == SECL_JOB_CLEAR_ALL)) begin
      wr_data = 16'hFFFF;
    end else if (job_byte_ff) begin
      wr_data = {job_data_ff[7:0], job_data_ff[7:0]};
    end else begin
      wr_data = job_data_ff;
    end
  end

  // Status display armed by a cycle start, dropped by a clocked one bit
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      stat_en_ff <= 1'b0;
    end else if (start_job) begin
      stat_en_ff <= 1'b1;
    end else if (sync2_ff[SECL_SY_CS] && sync2_ff[SECL_SY_FRAME]) begin
      stat_en_ff <= 1'b0;
    end
  end

  // Output pin: read data, else busy status, else floating
  always_comb begin
    nxt_serial_oe = sync2_ff[SECL_SY_CS] &&
                    (sync2_ff[SECL_SY_RDOE] ||
                     (stat_en_ff && !sync2_ff[SECL_SY_FRAME]));
    if (sync2_ff[SECL_SY_RDOE]) begin
      nxt_serial_out = sync2_ff[SECL_SY_RDBIT];
    end else begin
      nxt_serial_out = (sstate_ff == SECL_S_IDLE);
    end
  end

  // Output flops; the extra sync delay stays well inside the output delay budget
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      serial_out <= 1'b0;
      serial_oe_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      serial_out <= nxt_serial_out;
      serial_oe_out <= nxt_serial_oe;
      // Drops with the last count so the flag never outlasts the cycle
      busy_out <= start_job || ((sstate_ff == SECL_S_BUSY) && (ew_cnt_ff != EW_LAST));
    end
  end

  secl_mem #(
    .ROWS(SECL_ROWS),
    .AW(SECL_ROW_AW),
    .DW(SECL_WORD_W)
  ) u_mem (
    .wr_clk_in(sys_clk_in),
    .wr_en_in(wr_en),
    .wr_addr_in(wr_row),
    .wr_data_in(wr_data),
    .wr_be_in(wr_be),
    .rd_clk_in(serial_clk_in),
    .rd_en_in(mem_rd_en),
    .rd_addr_in(mem_rd_row),
    .rd_data_out(mem_rdata)
  );
endmodule
`default_nettype wire

// File: tb/secl_top_chk.sv
// Port assertions for the serial EEPROM command logic
`timescale 1ns/1ps
`default_nettype none
module secl_top_chk #(
  parameter int EW_CYCLES = 300
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic serial_clk_in,
  input wire logic chip_sel_in,
  input wire logic serial_in,
  input wire logic word_size_sel_in,
  input wire logic serial_out,
  input wire logic serial_oe_out,
  input wire logic busy_out
);
  int busy_cnt_ff;
  // Length of the running self-timed cycle
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !busy_out) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 1;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  reset_quiet_a: assert property (disable iff (1'b0) reset_in |=> !serial_oe_out && !busy_out)
    else $error("outputs active after reset");
  deselect_float_a: assert property (!chip_sel_in [*6] |-> !serial_oe_out)
    else $error("output driven while deselected");
  oe_select_a: assert property ($rose(serial_oe_out) |-> $past(chip_sel_in, 2))
    else $error("output enabled without select");
  busy_start_a: assert property ($rose(busy_out) |-> !$past(chip_sel_in, 2))
    else $error("cycle started while selected");
  busy_len_a: assert property (busy_cnt_ff <= EW_CYCLES)
    else $error("self-timed cycle too long");
  busy_min_a: assert property ($rose(busy_out) |=> busy_out [*8])
    else $error("self-timed cycle cut short");
  busy_once_a: assert property ($fell(busy_out) |=> !busy_out [*8])
    else $error("cycle restarted without a job");
  status_low_a: assert property ($rose(chip_sel_in) && busy_out ##1
    (chip_sel_in && busy_out && !serial_in) [*8] |-> serial_oe_out && !serial_out)
    else $error("busy status not shown");
endmodule
bind secl_top secl_top_chk #(.EW_CYCLES(EW_CYCLES)) secl_top_chk_inst (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .serial_clk_in(serial_clk_in),
  .chip_sel_in(chip_sel_in), .serial_in(serial_in), .word_size_sel_in(word_size_sel_in),
  .serial_out(serial_out), .serial_oe_out(serial_oe_out), .busy_out(busy_out));
`default_nettype wire

// File: tb/secl_host.sv
// Host-side serial controller model: select, link clock and data
`timescale 1ns/1ps
`default_nettype none
module secl_host (
  input wire logic dout_in,
  output logic sclk_out,
  output logic cs_out,
  output logic din_out
);
  // Link clock stands low between frames
  initial begin
    sclk_out = 1'b0;
    cs_out = 1'b0;
    din_out = 1'b0;
  end
  // One bit, data settled a half period before the rising edge
  task automatic tick(input logic b);
    din_out = b;
    #40 sclk_out = 1'b1;
    #40 sclk_out = 1'b0;
  endtask
  // Two idle zeros let the size select settle before any start bit
  task automatic select();
    cs_out = 1'b1;
    tick(1'b0);
    tick(1'b0);
  endtask
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      tick(v[i]);
    end
  endtask
  // Deselect time kept well above the minimum
  task automatic release_bus();
    cs_out = 1'b0;
    din_out = 1'b0;
    #300;
  endtask
  // Slow read clocking leaves room for the re-timed output
  task automatic grab(input int n, output logic [15:0] v);
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      tick(1'b0);
      #80 v = {v[14:0], dout_in};
    end
  endtask
endmodule
`default_nettype wire

// File: tb/secl_top_tb_top.sv
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/1ps
`default_nettype none
module secl_top_tb_top;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic wsel = 1'b1;
  wire sclk;
  wire cs;
  wire din;
  wire sout;
  wire doe;
  wire busy;
  wire dwire;
  int fail_count = 0;
  int total_checks = 0;
  logic [15:0] rd_v;
  always #12.5 sys_clk_in = ~sys_clk_in;
  // Released data line shows the inverse, never a stale copy
  assign dwire = doe ? sout : ~sout;
  secl_top #(.EW_CYCLES(300)) secl_top_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .serial_clk_in(sclk), .chip_sel_in(cs), .serial_in(din), .word_size_sel_in(wsel),
    .serial_out(sout), .serial_oe_out(doe), .busy_out(busy));
  secl_host secl_host_inst (.dout_in(dwire), .sclk_out(sclk), .cs_out(cs), .din_out(din));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 1000) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (busy !== lvl) begin
      check("busy wait", {15'h0000, lvl}, {15'h0000, busy});
      report_and_stop();
    end
  endtask
  task automatic cmd(input logic [31:0] v, input int n);
    secl_host_inst.select();
    secl_host_inst.send(v, n);
    secl_host_inst.release_bus();
  endtask
  task automatic job(input logic [31:0] v, input int n);
    cmd(v, n);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask
  // Header, then dummy zero, then data clocked out; frame left open
  task automatic rd(input logic [31:0] v, input int n, input int nb);
    secl_host_inst.select();
    secl_host_inst.send(v, n);
    #120;
    check("read enable", 16'h0001, {15'h0000, doe});
    check("dummy bit", 16'h0000, {15'h0000, sout});
    secl_host_inst.grab(nb, rd_v);
  endtask
  task automatic t_locked();
    cmd({5'h00, 11'h510, 16'h1234}, 27);
    repeat (40) @(negedge sys_clk_in);
    check("locked busy", 16'h0000, {15'h0000, busy});
  endtask
  task automatic t_clear();
    cmd(32'h0000_04C0, 11);
    job(32'h0000_0480, 11);
    rd(32'h0000_0610, 11, 16);
    secl_host_inst.release_bus();
    check("cleared word", 16'hFFFF, rd_v);
  endtask
  task automatic t_poll();
    cmd({5'h00, 11'h5FF, 16'h5A3C}, 27);
    wait_busy(1'b1);
    secl_host_inst.select();
    #250;
    check("status enable", 16'h0001, {15'h0000, doe});
    check("status busy", 16'h0000, {15'h0000, sout});
    wait_busy(1'b0);
    #150;
    check("status ready", 16'h0001, {15'h0000, sout});
    secl_host_inst.tick(1'b1);
    #150;
    check("status float", 16'h0000, {15'h0000, doe});
    secl_host_inst.release_bus();
  endtask
  // Last address wraps to the cleared first word
  task automatic t_wrap();
    rd(32'h0000_06FF, 11, 16);
    check("written word", 16'h5A3C, rd_v);
    secl_host_inst.grab(16, rd_v);
    secl_host_inst.release_bus();
    check("wrapped word", 16'hFFFF, rd_v);
  endtask
  task automatic t_erase_store();
    job(32'h0000_07FF, 11);
    rd(32'h0000_06FF, 11, 16);
    secl_host_inst.release_bus();
    check("erased word", 16'hFFFF, rd_v);
    job({5'h00, 11'h440, 16'hC3A5}, 27);
  endtask
  task automatic t_disable();
    cmd(32'h0000_0400, 11);
    cmd({5'h00, 11'h542, 16'h0000}, 27);
    repeat (40) @(negedge sys_clk_in);
    check("disabled busy", 16'h0000, {15'h0000, busy});
    rd(32'h0000_0642, 11, 16);
    secl_host_inst.release_bus();
    check("kept word", 16'hC3A5, rd_v);
  endtask
  // Odd byte lands in one half, the other half keeps its byte
  task automatic t_byte();
    @(negedge sys_clk_in);
    wsel = 1'b0;
    cmd(32'h0000_0980, 12);
    job({12'h000, 12'hA85, 8'h7E}, 20);
    rd(32'h0000_0C85, 12, 8);
    secl_host_inst.release_bus();
    check("written byte", 16'h007E, rd_v);
    rd(32'h0000_0C84, 12, 8);
    secl_host_inst.release_bus();
    check("other byte", 16'h00C3, rd_v);
  endtask
  // Main sequence, with a short stand-in for the power-up delay
  initial begin
    repeat (4) @(negedge sys_clk_in);
    check("oe in reset", 16'h0000, {15'h0000, doe});
    check("busy in reset", 16'h0000, {15'h0000, busy});
    reset_in = 1'b0;
    repeat (8) @(negedge sys_clk_in);
    t_locked();
    t_clear();
    t_poll();
    t_wrap();
    t_erase_store();
    t_disable();
    t_byte();
    report_and_stop();
  end
endmodule
`default_nettype wire
